//--- rtl/petsel_pkg.sv
// Package: register map, field positions, condition codes and carriers for the event-trigger select block
// Overview of operation
// - Pulse B only while its enable is set
// - Bits 14..12 choose pulse B condition
// - Pulse A only while its enable is set
// - Bits 10..8 choose pulse A condition
// - Interrupt request only while its enable is set
// - Bits 2..0 choose interrupt condition
// - Code 001 fires at counter zero
// - Code 010 fires at counter equal period
// - Codes 100/101 compare A up/down
// - Codes 110/111 compare B up/down
// - Pulse B clears tally, ignores status flag
// - Divider 00 off, else Nth event
package petsel_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_SEL    = 8'h00;  // Selection register
	localparam logic [7:0] OFF_PRESC  = 8'h04;  // Pulse B divider and tally
	localparam logic [7:0] OFF_STAT   = 8'h08;  // Sticky event status
	localparam logic [7:0] OFF_IEN    = 8'h0C;  // Interrupt enable mask
	localparam logic [7:0] OFF_ICLR   = 8'h10;  // Write-one-to-clear

	// Selection register fields
	localparam int SEL_B_EN   = 15;
	localparam int SEL_B_LSB  = 12;
	localparam int SEL_A_EN   = 11;
	localparam int SEL_A_LSB  = 8;
	localparam int SEL_I_EN   = 3;
	localparam int SEL_I_LSB  = 0;
	localparam logic [15:0] SEL_WMASK = 16'hFF0F;  // Bits 7..4 reserved
	localparam logic [15:0] SEL_RESET = 16'h0000;

	// Prescale register fields
	localparam int PRESC_DIV_LSB   = 12;
	localparam int PRESC_TALLY_LSB = 14;

	// Status bits
	localparam int ST_SOCA = 0;
	localparam int ST_SOCB = 1;
	localparam int ST_IRQ  = 2;
	localparam int ST_W    = 3;

	// Condition codes
	typedef enum logic [2:0] {
		COND_NONE0 = 3'h0,
		COND_ZERO  = 3'h1,
		COND_PRD   = 3'h2,
		COND_NONE3 = 3'h3,
		COND_CAU   = 3'h4,
		COND_CAD   = 3'h5,
		COND_CBU   = 3'h6,
		COND_CBD   = 3'h7
	} petsel_cond_t;

	// Time-base snapshot
	typedef struct packed {
		logic [15:0] count;   // Counter value
		logic [15:0] period;  // Period value
		logic [15:0] cmp_a;   // Compare A
		logic [15:0] cmp_b;   // Compare B
		logic        up;      // Counting up
	} petsel_tb_t;

	// Pulses to the outside
	typedef struct packed {
		logic soc_a;
		logic soc_b;
		logic irq;
	} petsel_evt_t;

endpackage

//--- rtl/petsel_cond.sv
// Condition decoder: one selector code against the time-base state
`timescale 1ns/1ps
`default_nettype none
module petsel_cond (
	input  wire logic [2:0]           code,     // Selector code
	input  wire petsel_pkg::petsel_tb_t tb,     // Time-base snapshot
	output logic                      hit       // Condition true this cycle
);
	// Comparisons
	wire eq_zero = (tb.count == 16'h0000);
	wire eq_prd  = (tb.count == tb.period);
	wire eq_a    = (tb.count == tb.cmp_a);
	wire eq_b    = (tb.count == tb.cmp_b);

	// Code decode
	always_comb begin
		unique case (petsel_pkg::petsel_cond_t'(code))
			petsel_pkg::COND_ZERO: hit = eq_zero;
			petsel_pkg::COND_PRD:  hit = eq_prd;
			petsel_pkg::COND_CAU:  hit = eq_a & tb.up;
			petsel_pkg::COND_CAD:  hit = eq_a & ~tb.up;
			petsel_pkg::COND_CBU:  hit = eq_b & tb.up;
			petsel_pkg::COND_CBD:  hit = eq_b & ~tb.up;
			petsel_pkg::COND_NONE0,
			petsel_pkg::COND_NONE3: hit = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

//--- rtl/petsel_edge.sv
// Rising-edge detector so a condition held for many cycles fires once
`timescale 1ns/1ps
`default_nettype none
module petsel_edge (
	input  wire logic pclk,     // Clock
	input  wire logic presetn,  // Async reset, low
	input  wire logic level,    // Condition level
	output logic      rise      // One-cycle pulse on rising level
);
	logic prev_r;  // Previous level

	// Remember last level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level;
		end
	end

	assign rise = level & ~prev_r;
endmodule
`default_nettype wire

//--- rtl/petsel_top.sv
// Event-trigger selection block with APB register file and interrupt
`timescale 1ns/1ps
`default_nettype none
module petsel_top (
	input  wire logic        pclk,                  // APB clock
	input  wire logic        presetn,               // Async reset, low
	input  wire logic        psel,                  // APB select
	input  wire logic        penable,               // APB enable
	input  wire logic        pwrite,                // APB direction
	input  wire logic [7:0]  paddr,                 // APB byte address
	input  wire logic [31:0] pwdata,                // APB write data
	output logic [31:0]      prdata,                // APB read data
	output logic             pready,                // APB ready
	output logic             pslverr,               // APB error
	input  wire logic [15:0] time_base_count,       // Time-base counter
	input  wire logic [15:0] time_base_period,      // Period value
	input  wire logic [15:0] compare_value_first,   // Compare A
	input  wire logic [15:0] compare_value_second,  // Compare B
	input  wire logic        count_up,              // Counter direction, 1 = up
	output logic             conv_start_a_pulse,    // ADC start A
	output logic             conv_start_b_pulse,    // ADC start B
	output logic             module_irq_request,    // Selected-event request pulse
	output logic             irq                    // Level interrupt
);
	// Registers
	logic [15:0]          event_trigger_selection_r;  // Selection register
	logic [1:0]           b_divider_r;                // Pulse B divider
	logic [1:0]           b_tally_r;                  // Pulse B event tally
	logic [1:0]           b_tally_nxt;                // Next tally
	logic [petsel_pkg::ST_W-1:0] status_r;            // Sticky status
	logic [petsel_pkg::ST_W-1:0] ien_r;               // Interrupt mask
	petsel_pkg::petsel_evt_t evt_r;                   // Registered pulses
	logic [31:0]          prdata_r;                   // Read data
	logic                 pready_r;                   // Ready
	logic                 pslverr_r;                  // Error
	logic                 irq_r;                      // Interrupt level

	// Time-base carrier
	petsel_pkg::petsel_tb_t tb;
	assign tb = '{count: time_base_count, period: time_base_period,
		cmp_a: compare_value_first, cmp_b: compare_value_second, up: count_up};

	// Selector fields
	wire [2:0] conv_start_b_condition = event_trigger_selection_r[petsel_pkg::SEL_B_LSB +: 3];
	wire [2:0] conv_start_a_condition = event_trigger_selection_r[petsel_pkg::SEL_A_LSB +: 3];
	wire [2:0] irq_request_condition  = event_trigger_selection_r[petsel_pkg::SEL_I_LSB +: 3];
	wire       conv_start_b_enable    = event_trigger_selection_r[petsel_pkg::SEL_B_EN];
	wire       conv_start_a_enable    = event_trigger_selection_r[petsel_pkg::SEL_A_EN];
	wire       irq_request_enable     = event_trigger_selection_r[petsel_pkg::SEL_I_EN];

	// Condition levels and edges
	logic [2:0] lvl;   // A, B, interrupt levels
	logic [2:0] hit;   // One-cycle events
	wire  [2:0] codes [3];
	assign codes[0] = conv_start_a_condition;
	assign codes[1] = conv_start_b_condition;
	assign codes[2] = irq_request_condition;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ch
			petsel_cond u_cond (
				.code  (codes[gi]),
				.tb    (tb),
				.hit   (lvl[gi])
			);
			petsel_edge u_edge (
				.pclk    (pclk),
				.presetn (presetn),
				.level   (lvl[gi]),
				.rise    (hit[gi])
			);
		end
	endgenerate

	// Pulse B divider: fire when tally reaches divider
	wire b_event = hit[1] & conv_start_b_enable;
	wire b_count_on = (b_divider_r != 2'b00);
	// Compare by magnitude so a tally left above a lowered divider fires, not wraps
	wire b_fire = b_event & b_count_on & (({1'b0, b_tally_r} + 3'd1) >= {1'b0, b_divider_r});
	wire a_fire = hit[0] & conv_start_a_enable;
	wire i_fire = hit[2] & irq_request_enable;

	// Tally next value
	always_comb begin
		if (!b_count_on) begin
			b_tally_nxt = 2'b00;               // Counter disabled
		end else if (b_fire) begin
			b_tally_nxt = 2'b00;
		end else if (b_event) begin
			b_tally_nxt = b_tally_r + 2'd1;    // Count selected event
		end else begin
			b_tally_nxt = b_tally_r;
		end
	end

	// APB decode
	wire acc      = psel & penable & ~pready_r;
	wire wr       = acc & pwrite;
	wire hit_sel  = (paddr == petsel_pkg::OFF_SEL);
	wire hit_pre  = (paddr == petsel_pkg::OFF_PRESC);
	wire hit_st   = (paddr == petsel_pkg::OFF_STAT);
	wire hit_ien  = (paddr == petsel_pkg::OFF_IEN);
	wire hit_clr  = (paddr == petsel_pkg::OFF_ICLR);
	wire mapped   = hit_sel | hit_pre | hit_st | hit_ien | hit_clr;
	wire [petsel_pkg::ST_W-1:0] clr_bits = (wr & hit_clr) ? pwdata[petsel_pkg::ST_W-1:0] : '0;
	wire [petsel_pkg::ST_W-1:0] set_bits = {i_fire, b_fire, a_fire};
	wire [31:0] rd_mux =
		hit_sel ? {16'h0000, event_trigger_selection_r} :
		hit_pre ? {16'h0000, b_tally_r, b_divider_r, 12'h000} :
		hit_st  ? {29'h0, status_r} :
		hit_ien ? {29'h0, ien_r} : 32'h0000_0000;

	// Registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_trigger_selection_r <= petsel_pkg::SEL_RESET;
			b_divider_r <= 2'b00;
			ien_r <= '0;
		end else if (wr) begin
			if (hit_sel) event_trigger_selection_r <= pwdata[15:0] & petsel_pkg::SEL_WMASK;
			if (hit_pre) b_divider_r <= pwdata[petsel_pkg::PRESC_DIV_LSB +: 2];
			if (hit_ien) ien_r <= pwdata[petsel_pkg::ST_W-1:0];
		end
	end

	// Tally and sticky status; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_tally_r <= 2'b00;
			status_r <= '0;
		end else begin
			b_tally_r <= b_tally_nxt;
			status_r <= (status_r & ~clr_bits) | set_bits;
		end
	end

	// Output pulses, interrupt and APB answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_r <= '0;
			irq_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			evt_r <= '{soc_a: a_fire, soc_b: b_fire, irq: i_fire};
			irq_r <= |(((status_r & ~clr_bits) | set_bits) & ien_r);
			pready_r <= acc;
			pslverr_r <= acc & ~mapped;
			prdata_r <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	assign conv_start_a_pulse = evt_r.soc_a;
	assign conv_start_b_pulse = evt_r.soc_b;
	assign module_irq_request = evt_r.irq;
	assign irq = irq_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule
`default_nettype wire

//--- dv/petsel_properties.sv
// Checker: port-level timing and selection properties of the event-trigger block
`timescale 1ns/1ps
`default_nettype none
module petsel_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] time_base_count,
	input wire logic        conv_start_a_pulse,
	input wire logic        conv_start_b_pulse,
	input wire logic        module_irq_request
);
	logic [15:0] sel_r;  // Shadow of the selection register
	logic [1:0]  div_r;  // Shadow of the pulse B divider
	// Follow register writes on the edge they take effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_r <= 16'h0000;
			div_r <= 2'b00;
		end else if (psel && penable && pwrite && !pready) begin
			if (paddr == petsel_pkg::OFF_SEL) sel_r <= pwdata[15:0];
			if (paddr == petsel_pkg::OFF_PRESC) div_r <= pwdata[petsel_pkg::PRESC_DIV_LSB +: 2];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready after access");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("stray read data");
	socb_enable_a: assert property (conv_start_b_pulse |-> $past(sel_r[15])) else $error("pulse B while off");
	soca_enable_a: assert property (conv_start_a_pulse |-> $past(sel_r[11])) else $error("pulse A while off");
	irq_enable_a: assert property (module_irq_request |-> $past(sel_r[3])) else $error("request while off");
	reserved_code_a: assert property (conv_start_a_pulse |-> !($past(sel_r[10:8]) inside {3'h0, 3'h3}))
		else $error("reserved code fired");
	zero_match_a: assert property (conv_start_a_pulse && $past(sel_r[10:8]) == 3'h1
		|-> $past(time_base_count) == 16'h0) else $error("zero event off zero");
	socb_divider_a: assert property (conv_start_b_pulse |-> $past(div_r) != 2'h0)
		else $error("pulse B with divider off");
	pulse_a_single_a: assert property (conv_start_a_pulse |=> !conv_start_a_pulse) else $error("pulse A too long");
	pulse_b_single_a: assert property (conv_start_b_pulse |=> !conv_start_b_pulse) else $error("pulse B too long");
	request_single_a: assert property (module_irq_request |=> !module_irq_request) else $error("request too long");
	cover property (module_irq_request);
	cover property (conv_start_a_pulse);
	cover property (conv_start_b_pulse);
	cover property (pslverr);
endmodule
bind petsel_top petsel_properties i_petsel_properties (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .time_base_count, .conv_start_a_pulse, .conv_start_b_pulse, .module_irq_request);
`default_nettype wire

//--- dv/petsel_sink.sv
// Far-side model: converter start inputs and interrupt controller tallying pulses
`timescale 1ns/1ps
`default_nettype none
module petsel_sink (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire petsel_pkg::petsel_evt_t evt,
	output logic [7:0]                   n_a,
	output logic [7:0]                   n_b,
	output logic [7:0]                   n_i
);
	// Each one-cycle pulse is one accepted start or request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			{n_a, n_b, n_i} <= 24'h000000;
		else
			{n_a, n_b, n_i} <= {n_a + evt.soc_a, n_b + evt.soc_b, n_i + evt.irq};
	end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Testbench: registers, condition codes, divider and interrupt of the select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, sa, sb, sr, irq, up;
	logic [7:0]  paddr, n_a, n_b, n_i;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] tbc, prd, cma, cmb;  // Time-base inputs
	int          num_errors, cmp_count;
	petsel_pkg::petsel_evt_t evt;
	assign evt = {sa, sb, sr};
	petsel_top i_petsel_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .time_base_count(tbc), .time_base_period(prd), .compare_value_first(cma),
		.compare_value_second(cmb), .count_up(up), .conv_start_a_pulse(sa), .conv_start_b_pulse(sb),
		.module_irq_request(sr), .irq);
	petsel_sink i_petsel_sink (.pclk, .presetn, .evt, .n_a, .n_b, .n_i);
	// One APB transfer, held until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Present one time-base condition for two cycles, then park
	task automatic ev(input logic [2:0] k);
		@(posedge pclk);
		tbc <= (k == 3'h1) ? 16'h0000 : (k == 3'h2) ? 16'h0064 : (k[2:1] == 2'h2) ? 16'h001E : 16'h003C;
		up  <= !k[0];
		repeat (2) @(posedge pclk);
		tbc <= 16'h0005;
		up  <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_regs();
		apb(1'b0, petsel_pkg::OFF_SEL, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b1, petsel_pkg::OFF_SEL, 32'h0000_FFFF);
		apb(1'b0, petsel_pkg::OFF_SEL, 32'h0);
		chk(rdat, 32'h0000_FF0F);
		apb(1'b0, 8'hFC, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdat, 32'h0);
	endtask
	// Every code against every condition, then all enables off
	task automatic t_codes();
		logic [7:0]  a0, b0, i0;
		logic [31:0] x;
		apb(1'b1, petsel_pkg::OFF_PRESC, 32'h0000_1000);
		for (int c = 0; c < 9; c++) begin
			x = (c == 0 || c == 3 || c == 8) ? 32'h0 : 32'h1;
			if (c < 8)
				apb(1'b1, petsel_pkg::OFF_SEL, {16'h0, 1'b1, c[2:0], 1'b1, c[2:0], 4'h0, 1'b1, c[2:0]});
			else
				apb(1'b1, petsel_pkg::OFF_SEL, 32'h0000_7707);
			{a0, b0, i0} = {n_a, n_b, n_i};
			for (int k = 1; k < 8; k++) if (k != 3) ev(k[2:0]);
			chk({24'h0, n_a - a0}, x);
			chk({24'h0, n_b - b0}, x);
			chk({24'h0, n_i - i0}, x);
		end
	endtask
	// Divider settings against six zero events, status left set
	task automatic t_div();
		logic [7:0] b0;
		apb(1'b1, petsel_pkg::OFF_SEL, 32'h0000_9000);
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, petsel_pkg::OFF_PRESC, d << 12);
			b0 = n_b;
			repeat (6) ev(3'h1);
			chk({24'h0, n_b - b0}, (d == 0) ? 0 : 6 / d);
			apb(1'b0, petsel_pkg::OFF_PRESC, 32'h0);
			chk(rdat, d << 12);
		end
		apb(1'b1, petsel_pkg::OFF_PRESC, 32'h0000_3000);
		ev(3'h1);
		apb(1'b0, petsel_pkg::OFF_PRESC, 32'h0);
		chk(rdat, 32'h0000_7000);
	endtask
	// Status, mask and clear of the level interrupt
	task automatic t_irq();
		apb(1'b1, petsel_pkg::OFF_ICLR, 32'h7);
		apb(1'b0, petsel_pkg::OFF_STAT, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b1, petsel_pkg::OFF_IEN, 32'h4);
		apb(1'b1, petsel_pkg::OFF_SEL, 32'h000A);
		ev(3'h2);
		apb(1'b0, petsel_pkg::OFF_STAT, 32'h0);
		chk(rdat, 32'h4);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, petsel_pkg::OFF_IEN, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, petsel_pkg::OFF_IEN, 32'h4);
		apb(1'b1, petsel_pkg::OFF_ICLR, 32'h4);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, petsel_pkg::OFF_STAT, 32'h0);
		chk(rdat, 32'h0);
	endtask
	task automatic print_verdict();
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		print_verdict();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		tbc = 16'h0005;
		up  = 1'b1;
		{prd, cma, cmb} = {16'h0064, 16'h001E, 16'h003C};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_codes();
		t_div();
		t_irq();
		print_verdict();
	end
endmodule
`default_nettype wire
